// ===== icl_defines.svh
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ICL_OFF_CTRL 8'h00
`define ICL_OFF_PEN_A 8'h01
`define ICL_OFF_PEN_B 8'h02
`define ICL_OFF_PFLG_A 8'h03
`define ICL_OFF_PFLG_B 8'h04
`define ICL_OFF_PCHG 8'h05
`define ICL_OFF_OPT 8'h06
`define ICL_OFF_STATE 8'h07
// ---------------------------------------------------------------
// control and option register bit positions
// ---------------------------------------------------------------
`define ICL_B_GIE 7
`define ICL_B_PERIPHERAL_GROUP_ENABLE 6
`define ICL_B_T0IE 5
`define ICL_B_EXTIE 4
`define ICL_B_CHGIE 3
`define ICL_B_T0IF 2
`define ICL_B_EXTIF 1
`define ICL_B_CHGIF 0
`define ICL_B_EDGE 6
// ---------------------------------------------------------------
// reset values and fixed numbers
// ---------------------------------------------------------------
`define ICL_RST_REG 8'h00
`define ICL_RST_OPT 8'h40
`define ICL_VECTOR 15'h0004
`define ICL_Q_LAST 2'h3
`endif

// ===== icl_pkg.sv
package icl_pkg;
   // entry sequencer states
   typedef enum logic [1:0] {
      ICL_IDLE = 2'b00,
      ICL_FLUSH = 2'b01,
      ICL_VEC = 2'b10
   } icl_state_e;
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } icl_bus_s;
   // commands toward the core
   typedef struct packed {
      logic flush;
      logic push_pc;
      logic save_ctx;
      logic load_vec;
      logic restore_ctx;
      logic pop_pc;
   } icl_core_cmd_s;
endpackage

// ===== icl_interrupt_control.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "icl_defines.svh"
module icl_interrupt_control
   import icl_pkg::*;
#(
   parameter int NUM_PCHG = 6 // interrupt-on-change pins
) (
   input wire logic clk,
   input wire logic rst,
   input wire icl_bus_s bus,
   output logic [7:0] rdata,
   input wire logic ext_pin, // external interrupt pin, asynchronous
   input wire logic t0_ovf, // timer0 overflow pulse
   input wire logic [NUM_PCHG-1:0] pchg_evt, // pin change pulses
   input wire logic [7:0] pevt_a, // peripheral group a pulses
   input wire logic [4:0] pevt_b, // peripheral group b pulses
   input wire logic [7:0] wake_ok_a, // group a sources that run asleep
   input wire logic [4:0] wake_ok_b, // group b sources that run asleep
   input wire logic q_phase_en, // one pulse per quarter phase
   input wire logic [1:0] q_phase, // current quarter, 0 is Q1
   input wire logic instr_boundary, // pulse at Q1 of a new fetch
   input wire logic sleeping, // core is in sleep
   input wire logic return_from_isr_exec, // return-from-isr executing
   output icl_core_cmd_s core_cmd,
   output logic [14:0] vector_addr,
   output logic wake,
   output logic irq_pending
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ctrl; // enables and flags
   logic [7:0] pen_a; // group a enables
   logic [4:0] pen_b; // group b enables
   logic [7:0] pflg_a; // group a flags
   logic [4:0] pflg_b; // group b flags
   logic [NUM_PCHG-1:0] pchg; // per-pin change flags
   logic edge_rise; // edge select
   icl_state_e state;
   logic ext_s1, ext_s2, ext_s3; // pin synchroniser and history
   logic [NUM_PCHG-1:0] next_pchg; // pin change flags after this cycle
   logic ext_edge_seen; // edge latched until sampling window
   logic req_q1; // request sampled at Q1
   logic wake_pend; // wake taken, one instruction still to run
   // write decode helper used for several registers
   function automatic logic hit(input icl_bus_s b, input logic [7:0] off);
      hit = b.wr && (b.addr == off);
   endfunction

   // ---------------------------------------------------------------
   // external pin edge detection
   // ---------------------------------------------------------------
   // asynchronous pin, edge detect
   // two flops before any logic reads the pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= ext_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end
   logic ext_edge;
   assign ext_edge = edge_rise ? (ext_s2 & ~ext_s3) : (~ext_s2 & ext_s3);
   logic ext_window; // Q4 or Q1
   assign ext_window = (q_phase == `ICL_Q_LAST) || (q_phase == 2'h0);
   // edge held until the flag may be set; asynchronous arrival
   // therefore costs up to two extra cycles of latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_edge_seen <= 1'b0;
      end else if (ext_edge && !ext_window) begin
         ext_edge_seen <= 1'b1;
      end else if (ext_window) begin
         ext_edge_seen <= 1'b0;
      end
   end
   logic ext_set;
   assign ext_set = ext_window && (ext_edge || ext_edge_seen);

   // ---------------------------------------------------------------
   // control register: enables, flags, global enable
   // ---------------------------------------------------------------
   logic take; // entry accepted this cycle
   logic [7:0] next_ctrl;
   always_comb begin
      next_ctrl = ctrl;
      if (hit(bus, `ICL_OFF_CTRL)) begin
         next_ctrl[7:1] = bus.wdata[7:1];
      end
      if (t0_ovf) begin
         next_ctrl[`ICL_B_T0IF] = 1'b1;
      end
      if (ext_set) begin
         next_ctrl[`ICL_B_EXTIF] = 1'b1;
      end
      next_ctrl[`ICL_B_CHGIF] = |next_pchg;
      if (take) begin
         next_ctrl[`ICL_B_GIE] = 1'b0;
      end
      if (return_from_isr_exec) begin
         next_ctrl[`ICL_B_GIE] = 1'b1;
      end
   end
   always_comb begin
      next_pchg = pchg;
      if (hit(bus, `ICL_OFF_PCHG)) begin
         next_pchg = pchg & bus.wdata[NUM_PCHG-1:0];
      end
      // set wins over a clear in the same cycle
      next_pchg = next_pchg | pchg_evt;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= `ICL_RST_REG;
         pchg <= '0;
      end else begin
         ctrl <= next_ctrl;
         pchg <= next_pchg;
      end
   end

   // ---------------------------------------------------------------
   // peripheral enables, flags, option
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pen_a <= `ICL_RST_REG;
         pen_b <= 5'h0_0;
         edge_rise <= 1'(`ICL_RST_OPT >> `ICL_B_EDGE);
      end else begin
         if (hit(bus, `ICL_OFF_PEN_A)) begin
            pen_a <= bus.wdata;
         end
         if (hit(bus, `ICL_OFF_PEN_B)) begin
            pen_b <= bus.wdata[7:3];
         end
         if (hit(bus, `ICL_OFF_OPT)) begin
            edge_rise <= bus.wdata[`ICL_B_EDGE];
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pflg_a <= `ICL_RST_REG;
         pflg_b <= 5'h0_0;
      end else begin
         pflg_a <= (hit(bus, `ICL_OFF_PFLG_A) ? bus.wdata : pflg_a) | pevt_a;
         pflg_b <= (hit(bus, `ICL_OFF_PFLG_B) ? bus.wdata[7:3] : pflg_b) | pevt_b;
      end
   end

   // ---------------------------------------------------------------
   // request formation
   // ---------------------------------------------------------------
   logic core_req, periph_req, req_raw;
   assign core_req = (ctrl[`ICL_B_T0IE] & ctrl[`ICL_B_T0IF])
      | (ctrl[`ICL_B_EXTIE] & ctrl[`ICL_B_EXTIF])
      | (ctrl[`ICL_B_CHGIE] & ctrl[`ICL_B_CHGIF]);
   assign periph_req = ctrl[`ICL_B_PERIPHERAL_GROUP_ENABLE] & (|(pen_a & pflg_a) | |(pen_b & pflg_b));
   assign req_raw = core_req | periph_req;
   assign irq_pending = req_raw;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q1 <= 1'b0;
      end else if (q_phase_en && q_phase == 2'h0) begin
         req_q1 <= req_raw;
      end
   end

   // ---------------------------------------------------------------
   // wake from sleep
   // ---------------------------------------------------------------
   logic wake_src;
   assign wake_src = (ctrl[`ICL_B_EXTIE] & ctrl[`ICL_B_EXTIF])
      | (ctrl[`ICL_B_CHGIE] & ctrl[`ICL_B_CHGIF])
      | (ctrl[`ICL_B_PERIPHERAL_GROUP_ENABLE] & (|(pen_a & pflg_a & wake_ok_a)
      | |(pen_b & pflg_b & wake_ok_b)));
   assign wake = sleeping & wake_src;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_pend <= 1'b0;
      end else if (wake) begin
         wake_pend <= 1'b1;
      end else if (instr_boundary) begin
         wake_pend <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // entry sequencer
   // ---------------------------------------------------------------
   // ignored while global clear
   // taken at any fetch boundary not in sleep, wake_pend or a return, instruction length ignored
   assign take = (state == ICL_IDLE) && instr_boundary && req_q1
      && ctrl[`ICL_B_GIE] && !sleeping && !wake_pend && !return_from_isr_exec;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ICL_IDLE;
      end else begin
         case (state)
            ICL_IDLE: begin
               if (take) begin
                  state <= ICL_FLUSH;
               end
            end
            ICL_FLUSH: begin
               if (instr_boundary) begin
                  state <= ICL_VEC;
               end
            end
            ICL_VEC: begin
               state <= ICL_IDLE;
            end
            default: begin
               state <= ICL_IDLE;
            end
         endcase
      end
   end
   // Q1 sample, flush cycle, vector: 9-12 clocks from a synchronous request to load_vec
   // entry and return commands; the core saves W, status, bank, fsr, pclath
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_cmd <= '0;
         vector_addr <= '0;
      end else begin
         core_cmd.flush <= take;
         core_cmd.push_pc <= take;
         core_cmd.save_ctx <= take;
         core_cmd.load_vec <= (state == ICL_FLUSH) && instr_boundary;
         core_cmd.restore_ctx <= return_from_isr_exec;
         core_cmd.pop_pc <= return_from_isr_exec;
         vector_addr <= `ICL_VECTOR;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (bus.rd) begin
         case (bus.addr)
            `ICL_OFF_CTRL: rdata <= ctrl;
            `ICL_OFF_PEN_A: rdata <= pen_a;
            `ICL_OFF_PEN_B: rdata <= {pen_b, 3'h0};
            `ICL_OFF_PFLG_A: rdata <= pflg_a;
            `ICL_OFF_PFLG_B: rdata <= {pflg_b, 3'h0};
            `ICL_OFF_PCHG: rdata <= 8'(pchg);
            `ICL_OFF_OPT: rdata <= {1'b0, edge_rise, 6'h0};
            `ICL_OFF_STATE: rdata <= {5'h0, wake_pend, 2'(state)};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_rst_disabled;
      @(posedge clk) $fell(rst) |-> !ctrl[`ICL_B_GIE];
   endproperty
   a_rst_disabled: assert property (p_rst_disabled) else $error("gie set after reset");
   property p_take_gated;
      @(posedge clk) disable iff (rst) take |-> ctrl[`ICL_B_GIE] && req_q1;
   endproperty
   a_take_gated: assert property (p_take_gated) else $error("entry without enable");
   property p_t0_flag;
      @(posedge clk) disable iff (rst) t0_ovf |=> ctrl[`ICL_B_T0IF];
   endproperty
   a_t0_flag: assert property (p_t0_flag) else $error("flag not set");
   property p_entry;
      @(posedge clk) disable iff (rst) take && !return_from_isr_exec |=>
         !ctrl[`ICL_B_GIE] && core_cmd.flush && core_cmd.push_pc && core_cmd.save_ctx;
   endproperty
   a_entry: assert property (p_entry) else $error("entry actions missing");
   property p_vec;
      @(posedge clk) disable iff (rst) core_cmd.load_vec |-> vector_addr == `ICL_VECTOR;
   endproperty
   a_vec: assert property (p_vec) else $error("wrong vector");
   property p_no_vec_in_isr;
      @(posedge clk) disable iff (rst) !ctrl[`ICL_B_GIE] |-> !take;
   endproperty
   a_no_vec_in_isr: assert property (p_no_vec_in_isr) else $error("vector with gie clear");
   property p_ret;
      @(posedge clk) disable iff (rst) return_from_isr_exec |=>
         ctrl[`ICL_B_GIE] && core_cmd.pop_pc && core_cmd.restore_ctx;
   endproperty
   a_ret: assert property (p_ret) else $error("return incomplete");
   property p_chg_summary;
      @(posedge clk) disable iff (rst) ##1 ctrl[`ICL_B_CHGIF] == (|pchg);
   endproperty
   a_chg_summary: assert property (p_chg_summary) else $error("summary mismatch");
endmodule
`default_nettype wire

// ===== icl_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// core sequencer stand-in
// ------------------------------------------
module icl_core_model
   import icl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire icl_core_cmd_s core_cmd,
   input wire logic [14:0] vector_addr,
   input wire logic ret_req, // bench asks for a return
   output logic q_phase_en,
   output logic [1:0] q_phase,
   output logic instr_boundary,
   output logic return_from_isr_exec,
   output logic [14:0] pc, // fetch address seen by the core
   output logic [3:0] depth // return stack depth
);
   // one quarter per clock, four clocks per instruction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_phase <= 2'h0;
      end else begin
         q_phase <= q_phase + 2'h1;
      end
   end
   assign q_phase_en = !rst;
   assign instr_boundary = !rst && (q_phase == 2'h0);
   // return only lands on a fetch boundary, one cycle long
   assign return_from_isr_exec = ret_req && instr_boundary;
   // pc and stack follow the entry and return commands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pc <= 15'h0000;
         depth <= 4'h0;
      end else begin
         if (core_cmd.push_pc) begin
            depth <= depth + 4'h1;
         end else if (core_cmd.pop_pc) begin
            depth <= depth - 4'h1;
         end
         if (core_cmd.load_vec) begin
            pc <= vector_addr;
         end else if (instr_boundary) begin
            pc <= pc + 15'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import icl_pkg::*;
   logic clk, rst, ext_pin, t0_ovf, sleeping, ret_req;
   logic q_phase_en, instr_boundary, return_from_isr_exec, wake, irq_pending;
   icl_bus_s bus;
   icl_core_cmd_s core_cmd;
   logic [5:0] pchg_evt;
   logic [7:0] pevt_a, wake_ok_a, rdata, d, v, e;
   logic [4:0] pevt_b, wake_ok_b, vb;
   logic [1:0] q_phase;
   logic [14:0] vector_addr, pc;
   logic [3:0] depth;
   int failures, cmp_count, cyc, c, c2, n, seed;
   icl_interrupt_control uut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .ext_pin(ext_pin), .t0_ovf(t0_ovf), .pchg_evt(pchg_evt), .pevt_a(pevt_a),
      .pevt_b(pevt_b), .wake_ok_a(wake_ok_a), .wake_ok_b(wake_ok_b),
      .q_phase_en(q_phase_en), .q_phase(q_phase), .instr_boundary(instr_boundary),
      .sleeping(sleeping), .return_from_isr_exec(return_from_isr_exec), .core_cmd(core_cmd),
      .vector_addr(vector_addr), .wake(wake), .irq_pending(irq_pending));
   icl_core_model core (.clk(clk), .rst(rst), .core_cmd(core_cmd),
      .vector_addr(vector_addr), .ret_req(ret_req), .q_phase_en(q_phase_en),
      .q_phase(q_phase), .instr_boundary(instr_boundary), .return_from_isr_exec(return_from_isr_exec),
      .pc(pc), .depth(depth));
   // ------------------------------------------
   // clock, hang guard, helpers
   // ------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // run needs about 250 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      chk8({7'h00, got}, {7'h00, exp}, m);
   endtask
   // bus write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk) bus <= '{a, x, 1'b1, 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
   endtask
   // bus read, data stands in the following cycle only
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      @(negedge clk) x = rdata;
   endtask
   task automatic t0_pulse;
      @(posedge clk) t0_ovf <= 1'b1;
      @(posedge clk) t0_ovf <= 1'b0;
      #1;
   endtask
   // wait for flush (0), load_vec (1) or restore (2), bounded
   task automatic wt(input int k, input int lim, output int cn);
      cn = 0;
      while (cn < lim && !(k == 0 ? core_cmd.flush === 1'b1 : k == 1 ?
             core_cmd.load_vec === 1'b1 : core_cmd.restore_ctx === 1'b1)) begin
         @(posedge clk);
         #1;
         cn++;
      end
   endtask
   // return from service, restore must arrive within 8 cycles
   task automatic ret;
      ret_req <= 1'b1;
      wt(2, 8, c);
      ret_req <= 1'b0;
      chk1(c < 8, 1'b1, "return restore");
   endtask
   // ------------------------------------------
   // main sequence
   // ------------------------------------------
   initial begin
      seed = $urandom(9);
      {rst, ext_pin, t0_ovf, sleeping, ret_req} = 5'b10000;
      bus = '0;
      {pchg_evt, pevt_a, pevt_b, wake_ok_a, wake_ok_b} = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'h00, d); chk8(d, 8'h00, "ctrl after reset");
      rd(8'h06, d); chk8(d, 8'h40, "option after reset");
      rd(8'h20, d); chk8(d, 8'h00, "unmapped read");
      chk1(vector_addr === 15'h0004, 1'b1, "vector");
      // flags with every enable off
      t0_pulse();
      rd(8'h00, d); chk8(d, 8'h04, "t0 flag");
      chk1(irq_pending, 1'b0, "no pending");
      wr(8'h00, 8'h00);
      @(posedge clk) pchg_evt <= 6'h21;
      @(posedge clk) pchg_evt <= 6'h00;
      rd(8'h05, d); chk8(d, 8'h21, "change flags");
      wr(8'h00, 8'h00);
      rd(8'h00, d); chk8(d, 8'h01, "summary read only");
      wr(8'h05, 8'h00);
      rd(8'h00, d); chk8(d, 8'h00, "summary clears");
      $display("test flags done");
      // random peripheral groups, gated by the group enable
      for (n = 0; n < 6; n++) begin
         {v, e, vb} = 21'($urandom);
         wr(8'h01, e);
         @(posedge clk) {pevt_a, pevt_b} <= {v, vb};
         @(posedge clk) {pevt_a, pevt_b} <= '0;
         rd(8'h03, d); chk8(d, v, "group a flags");
         rd(8'h04, d); chk8(d, {vb, 3'b000}, "group b flags");
         chk1(irq_pending, 1'b0, "group gate off");
         wr(8'h00, 8'h40);
         @(negedge clk) chk1(irq_pending, |(v & e), "group gate on");
         wr(8'h03, 8'h00);
         wr(8'h04, 8'h00);
         wr(8'h00, 8'h00);
      end
      $display("test groups done");
      // synchronous entry, blocked while serving, pending re-entry
      wr(8'h00, 8'hA0);
      t0_pulse();
      wt(0, 8, c); chk1(core_cmd.push_pc & core_cmd.save_ctx, 1'b1, "entry");
      wt(1, 8, c2); chk1(c + c2 <= 12, 1'b1, "sync latency");
      // pc takes the vector at the edge after load_vec
      @(posedge clk);
      @(negedge clk) chk1(pc === 15'h0004, 1'b1, "pc at vector");
      rd(8'h00, d); chk8(d, 8'h24, "global cleared");
      t0_pulse();
      wt(0, 12, c); chk1(core_cmd.flush, 1'b0, "no vector in service");
      ret();
      wt(0, 8, c); chk1(core_cmd.flush, 1'b1, "pending serviced");
      wt(1, 8, c);
      wr(8'h00, 8'h20);
      ret();
      rd(8'h00, d); chk8(d, 8'hA0, "global set on return");
      chk8({4'h0, depth}, 8'h00, "stack popped");
      $display("test entry done");
      // pin edges, both selections; synchroniser and window need 6 edges
      wr(8'h00, 8'h00);
      @(posedge clk) ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h00, d); chk8(d, 8'h02, "rising edge");
      wr(8'h06, 8'h00);
      wr(8'h00, 8'h00);
      @(posedge clk) ext_pin <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h00, d); chk8(d, 8'h02, "falling edge");
      wr(8'h00, 8'h00);
      @(posedge clk) ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h00, d); chk8(d, 8'h00, "wrong edge ignored");
      wr(8'h00, 8'h90);
      @(posedge clk) #(1 + $urandom % 4);
      ext_pin <= 1'b0;
      wt(0, 10, c); wt(1, 8, c2);
      chk1(c + c2 <= 16, 1'b1, "async latency");
      wr(8'h00, 8'h10);
      ret();
      $display("test pin done");
      // sleep wake only from enabled clockless sources
      wr(8'h00, 8'h40);
      wr(8'h01, 8'h03);
      wake_ok_a <= 8'h01;
      sleeping <= 1'b1;
      @(posedge clk) pevt_a <= 8'h02;
      @(posedge clk) pevt_a <= 8'h00;
      @(negedge clk) chk1(wake, 1'b0, "clocked source no wake");
      @(posedge clk) pevt_a <= 8'h01;
      @(posedge clk) pevt_a <= 8'h00;
      @(negedge clk) chk1(wake, 1'b1, "wake");
      @(posedge clk) sleeping <= 1'b0;
      wt(0, 12, c); chk1(core_cmd.flush, 1'b0, "wake continues");
      $display("test sleep done");
      summarize();
   end
endmodule
`default_nettype wire
